/* File: src/sba_arbiter.sv */
// secondary bus arbiter with grant time-out and request masking
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter (
   // clock and resets
   input  wire logic              CLOCK_IN,
   input  wire logic              RST_N_IN,
   input  wire logic              GLOBAL_RST_N_IN,
   // configuration access
   input  wire sba_pkg::sba_cfg_s CFG_IN,
   output logic [7:0]             CFG_RDATA_OUT,
   // secondary bus requests and bus state
   input  wire logic [5:0]        REQ_N_IN,
   input  wire logic              BRIDGE_REQ_IN,
   input  wire logic              FRAME_N_IN,
   input  wire logic              IRDY_N_IN,
   // grants
   output logic [5:0]             GNT_N_OUT,
   output logic                   BRIDGE_GNT_OUT
);
   import sba_pkg::*;

   sba_state_s         st;
   sba_state_s         nx;
   logic               fundamental_reset_n;
   logic               bus_idle;
   logic               tmo_en;
   logic               auto_en;
   logic               req0_ign;
   logic [NUM_MST-1:0] req_vec;
   logic [NUM_MST-1:0] masked;
   logic [NUM_MST-1:0] elig;
   logic [NUM_MST-1:0] high;
   logic [NUM_MST-1:0] grant;
   logic [3:0]         pick_hi;
   logic [3:0]         pick_lo;
   logic [2:0]         park_idx;
   logic               expire;
   logic               tmo_fire;
   logic               wait_cond;

   // next master after ptr in rotation order; msb says one was found
   function automatic logic [3:0] rr_pick(input logic [NUM_MST-1:0] vec,
                                          input logic [2:0]         ptr);
      logic [3:0] res;
      logic [2:0] idx;
      res = 4'h0;
      for (int i = NUM_MST; i >= 1; i--) begin
         idx = 3'((int'(ptr) + i) % NUM_MST);
         if (vec[idx]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction

   // either reset input loads every field's reset value; a glitch on either also resets
   assign fundamental_reset_n = RST_N_IN & GLOBAL_RST_N_IN;

   // pci pins are synchronous to the pci clock, so no synchroniser
   assign bus_idle = FRAME_N_IN & IRDY_N_IN;
   assign tmo_en   = st.req_mask[BIT_TMO_EN];
   assign auto_en  = st.req_mask[BIT_AUTO_MASK];
   assign req0_ign = st.req_mask[BIT_REQ0_IGN];
   assign req_vec  = {BRIDGE_REQ_IN, ~REQ_N_IN};

   // masking: timed-out requests while auto masking, and request zero while ignored
   assign masked = {1'b0, st.tmo_flags & {NUM_REQ{auto_en}}}
                 | {6'h00, req0_ign};
   assign elig   = req_vec & ~masked;
   assign high   = {st.arb_ctrl[BIT_BRG_TIER], 5'h00, st.arb_ctrl[BIT_TIER0]};
   assign pick_hi = rr_pick(elig & high, st.rr_hi);
   assign pick_lo = rr_pick(elig & ~high, st.rr_lo);

   // never park on a masked master; the bridge is always safe
   assign park_idx = (st.arb_ctrl[BIT_PARK] || masked[st.last]) ? BRIDGE_IDX
                   : st.last;

   // idle cycles after the grant, with frame still high
   assign wait_cond = (st.state == ARB_WAIT) && bus_idle;
   assign tmo_fire  = wait_cond && expire && (st.owner != BRIDGE_IDX);

   sba_grant_timer #(
      .LIMIT      (TMO_CLKS)
   ) sba_grant_timer_inst (
      .clk_in     (CLOCK_IN),
      .rst_n_in   (fundamental_reset_n),
      .count_in   (wait_cond),
      .enable_in  (tmo_en),
      .expire_out (expire)
   );

   // register access, then arbitration; a flag set beats a read clear
   always_comb begin
      nx    = st;
      grant = '0;
      if (CFG_IN.wr && CFG_IN.addr == OFS_ARB_CTRL) begin
         nx.arb_ctrl = CFG_IN.wdata;
      end
      if (CFG_IN.wr && CFG_IN.addr == OFS_REQ_MASK) begin
         nx.req_mask = CFG_IN.wdata; // reserved bits stored as written
      end
      if (CFG_IN.rd) begin
         case (CFG_IN.addr)
            OFS_ARB_CTRL: nx.rdata = st.arb_ctrl;
            OFS_REQ_MASK: nx.rdata = st.req_mask;
            OFS_TMO_FLAG: begin
               nx.rdata     = {2'b00, st.tmo_flags};
               nx.tmo_flags = '0;
            end
            default:      nx.rdata = 8'h00;
         endcase
      end
      case (st.state)
         ARB_IDLE: begin
            if (!bus_idle) begin
               // the parked master started a transaction on its own
               nx.state = ARB_OWNED;
               nx.owner = park_idx;
               nx.last  = park_idx;
               grant    = 7'h01 << park_idx;
            end else if (pick_hi[3]) begin
               nx.state = ARB_WAIT;
               nx.owner = pick_hi[2:0];
               nx.rr_hi = pick_hi[2:0];
               grant    = 7'h01 << pick_hi[2:0];
            end else if (pick_lo[3]) begin
               nx.state = ARB_WAIT;
               nx.owner = pick_lo[2:0];
               nx.rr_lo = pick_lo[2:0];
               grant    = 7'h01 << pick_lo[2:0];
            end else begin
               grant = 7'h01 << park_idx;
            end
         end
         ARB_WAIT: begin
            if (!FRAME_N_IN) begin
               nx.state = ARB_OWNED;
               nx.last  = st.owner;
               grant    = 7'h01 << st.owner;
            end else if (tmo_fire) begin
               nx.state = ARB_IDLE;
               nx.tmo_flags[st.owner] = 1'b1;
            end else if (!elig[st.owner]) begin
               nx.state = ARB_IDLE;
            end else begin
               grant = 7'h01 << st.owner;
            end
         end
         ARB_OWNED: begin
            // grant held through the transaction; rearbitrate once idle
            if (bus_idle) begin
               nx.state = ARB_IDLE;
            end else begin
               grant = 7'h01 << st.owner;
            end
         end
         default: begin
            nx.state = ARB_IDLE;
         end
      endcase
      nx.gnt_n   = ~grant[NUM_REQ-1:0];
      nx.brg_gnt = grant[BRIDGE_IDX];
   end

   // all fields take their documented defaults on fundamental reset
   always_ff @(posedge CLOCK_IN or negedge fundamental_reset_n) begin
      if (!fundamental_reset_n) begin
         st <= '{state: ARB_IDLE, arb_ctrl: RST_ARB_CTRL,
                 req_mask: RST_REQ_MASK, tmo_flags: RST_TMO_FLAG,
                 owner: BRIDGE_IDX, last: BRIDGE_IDX, rr_hi: BRIDGE_IDX,
                 rr_lo: BRIDGE_IDX, gnt_n: '1, brg_gnt: 1'b0, rdata: 8'h00};
      end else begin
         st <= nx;
      end
   end

   assign CFG_RDATA_OUT  = st.rdata;
   assign GNT_N_OUT      = st.gnt_n;
   assign BRIDGE_GNT_OUT = st.brg_gnt;

   // checks on time-out, masking, priority and parking
   sequence s_wait16;
      (wait_cond && tmo_en && st.owner != BRIDGE_IDX)[*8]
      ##1 (wait_cond && tmo_en && st.owner != BRIDGE_IDX)[*8];
   endsequence

   property p_tmo_needs_en;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      ((st.tmo_flags & ~$past(st.tmo_flags)) != 6'h00) |-> $past(tmo_en);
   endproperty
   a_tmo_needs_en: assert property (p_tmo_needs_en)
      else $error("time-out flag set while time-out disabled");

   property p_tmo_at_16;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      s_wait16 |=> (st.state == ARB_IDLE) && st.tmo_flags[$past(st.owner)]
                   && (st.gnt_n == 6'h3f);
   endproperty
   a_tmo_at_16: assert property (p_tmo_at_16)
      else $error("no time-out after 16 idle clocks");

   property p_tmo_not_early;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      tmo_fire |-> $past(wait_cond, 15);
   endproperty
   a_tmo_not_early: assert property (p_tmo_not_early)
      else $error("time-out before 16 idle clocks");

   property p_auto_mask;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      (tmo_fire && auto_en && !(CFG_IN.wr && CFG_IN.addr == OFS_REQ_MASK))
      |=> masked[$past(st.owner)] && !grant[$past(st.owner)];
   endproperty
   a_auto_mask: assert property (p_auto_mask)
      else $error("timed-out request not masked");

   property p_req0_ignored;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      $fell(GNT_N_OUT[0]) |-> !$past(req0_ign);
   endproperty
   a_req0_ignored: assert property (p_req0_ignored)
      else $error("request zero granted while ignored");

   property p_rc_read;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      (CFG_IN.rd && CFG_IN.addr == OFS_TMO_FLAG)
      |=> (CFG_RDATA_OUT == {2'b00, $past(st.tmo_flags)})
          && ($past(tmo_fire) || st.tmo_flags == 6'h00);
   endproperty
   a_rc_read: assert property (p_rc_read)
      else $error("status read did not return and clear flags");

   property p_tier;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      (st.state == ARB_IDLE && bus_idle && (elig & high) != 7'h00)
      |=> (st.state == ARB_WAIT) && (($past(high) & (7'h01 << st.owner)) != 7'h00);
   endproperty
   a_tier: assert property (p_tier)
      else $error("lower tier won over a higher tier request");

   property p_park;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      (st.state == ARB_IDLE && bus_idle && elig == 7'h00 && st.arb_ctrl[BIT_PARK])
      |=> BRIDGE_GNT_OUT && (GNT_N_OUT == 6'h3f);
   endproperty
   a_park: assert property (p_park)
      else $error("idle bus not parked on bridge");

   property p_masked_no_grant;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      ($past(st.state) == ARB_IDLE && st.state == ARB_WAIT)
      |-> (($past(masked) & (7'h01 << st.owner)) == 7'h00)
          && $onehot({BRIDGE_GNT_OUT, ~GNT_N_OUT});
   endproperty
   a_masked_no_grant: assert property (p_masked_no_grant)
      else $error("masked request received a grant");

   property p_one_grant;
      @(posedge CLOCK_IN) disable iff (!fundamental_reset_n)
      $onehot0({BRIDGE_GNT_OUT, ~GNT_N_OUT});
   endproperty
   a_one_grant: assert property (p_one_grant)
      else $error("more than one grant asserted");
endmodule
`default_nettype wire

/* File: src/sba_pkg.sv */
// shared constants and types of the secondary bus arbiter
package sba_pkg;
   // masters on the secondary bus
   localparam int unsigned NUM_REQ       = 6;
   localparam int unsigned NUM_MST       = 7;
   localparam logic [2:0]  BRIDGE_IDX    = 3'h6;
   // configuration byte offsets
   localparam logic [7:0]  OFS_ARB_CTRL  = 8'hdc;
   localparam logic [7:0]  OFS_REQ_MASK  = 8'hdd;
   localparam logic [7:0]  OFS_TMO_FLAG  = 8'hde;
   // reset values
   localparam logic [7:0]  RST_ARB_CTRL  = 8'h40;
   localparam logic [7:0]  RST_REQ_MASK  = 8'h00;
   localparam logic [5:0]  RST_TMO_FLAG  = 6'h00;
   // arbiter control fields
   localparam int unsigned BIT_PARK      = 7;
   localparam int unsigned BIT_BRG_TIER  = 6;
   localparam int unsigned BIT_TIER0     = 0;
   // request mask fields
   localparam int unsigned BIT_TMO_EN    = 7;
   localparam int unsigned BIT_AUTO_MASK = 6;
   localparam int unsigned BIT_REQ0_IGN  = 0;
   // grant time-out, in pci clocks
   localparam int unsigned TMO_CLKS      = 16;
   localparam int unsigned TMO_CNT_W     = 5;

   typedef enum logic [1:0] {ARB_IDLE, ARB_WAIT, ARB_OWNED} sba_arb_e;

   // configuration access from the bridge's config space decoder
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sba_cfg_s;

   typedef struct packed {
      sba_arb_e           state;
      logic [7:0]         arb_ctrl;
      logic [7:0]         req_mask;
      logic [NUM_REQ-1:0] tmo_flags;
      logic [2:0]         owner;
      logic [2:0]         last;
      logic [2:0]         rr_hi;
      logic [2:0]         rr_lo;
      logic [NUM_REQ-1:0] gnt_n;
      logic               brg_gnt;
      logic [7:0]         rdata;
   } sba_state_s;

   typedef struct packed {
      logic [TMO_CNT_W-1:0] cnt;
   } sba_tmr_s;
endpackage

/* File: src/sba_grant_timer.sv */
// idle-bus counter that times a granted master's frame start
`timescale 1ns/1ps
`default_nettype none
module sba_grant_timer #(
   parameter int unsigned LIMIT = sba_pkg::TMO_CLKS
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // control
   input  wire logic count_in,
   input  wire logic enable_in,
   // result
   output logic      expire_out
);
   import sba_pkg::*;

   localparam logic [TMO_CNT_W-1:0] LAST = TMO_CNT_W'(LIMIT - 1);

   sba_tmr_s st;
   sba_tmr_s nx;

   // count idle cycles; saturate so a disabled time-out never wraps
   always_comb begin
      nx = st;
      if (!count_in) begin
         nx.cnt = '0;
      end else if (st.cnt != LAST) begin
         nx.cnt = st.cnt + 1'b1;
      end
   end

   // expiry on the last idle cycle of the window
   assign expire_out = enable_in & count_in & (st.cnt == LAST);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '{cnt: '0};
      end else begin
         st <= nx;
      end
   end
endmodule
`default_nettype wire

/* File: tb/sba_mst_model.sv */
// behavioural secondary bus masters that run one short frame per grant
`timescale 1ns/1ps
`default_nettype none
module sba_mst_model (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // scenario controls and grants
   input  wire logic [5:0] want_in,
   input  wire logic [5:0] resp_in,
   input  wire logic [5:0] gnt_n_in,
   // bus side
   output logic [5:0]      req_n_out,
   output logic            frame_n_out,
   output logic            irdy_n_out
);
   logic [1:0] ph_q;
   // a silent master never starts a frame, so the pulled-up lines stay high
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_n_out <= 6'h3f;
         ph_q      <= 2'h0;
      end else begin
         req_n_out <= ~want_in;
         if (ph_q != 2'h0 || (|(want_in & resp_in & ~gnt_n_in))) begin
            ph_q <= ph_q + 2'h1;
         end
      end
   end
   // two data phases, then irdy alone for the last one
   assign frame_n_out = !(ph_q == 2'h1 || ph_q == 2'h2);
   assign irdy_n_out  = (ph_q == 2'h0);
endmodule
`default_nettype wire

/* File: tb/sba_arbiter_test.sv */
// self-checking bench of the secondary bus arbiter
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter_test;
   import sba_pkg::*;
   logic       clock  = 1'b0;
   logic       rst_n  = 1'b0;
   logic       global_reset_n_n = 1'b1;
   logic       brg_req = 1'b0;
   sba_cfg_s   cfg    = '0;
   logic [5:0] want   = 6'h00;
   logic [5:0] resp   = 6'h00;
   logic [7:0] rdata;
   logic [5:0] req_n, gnt_n;
   logic       frame_n, irdy_n, brg_gnt;
   int         failures = 0;
   int         total_checks = 0;
   // free-running bus clock
   always #20 clock = ~clock;
   sba_arbiter sba_arbiter_inst (.CLOCK_IN(clock), .RST_N_IN(rst_n), .GLOBAL_RST_N_IN(global_reset_n_n),
      .CFG_IN(cfg), .CFG_RDATA_OUT(rdata), .REQ_N_IN(req_n), .BRIDGE_REQ_IN(brg_req),
      .FRAME_N_IN(frame_n), .IRDY_N_IN(irdy_n), .GNT_N_OUT(gnt_n), .BRIDGE_GNT_OUT(brg_gnt));
   sba_mst_model sba_mst_model_inst (.clk_in(clock), .rst_n_in(rst_n), .want_in(want),
      .resp_in(resp), .gnt_n_in(gnt_n), .req_n_out(req_n), .frame_n_out(frame_n),
      .irdy_n_out(irdy_n));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // byte access; the strobe drops at the next edge so reads never double up
   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      cfg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      cfg <= '0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      cfg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock);
      cfg <= '0;
      #1;
      chk(what, exp, rdata);
   endtask
   task automatic wait_gnt(input int i, input int lim);
      int n;
      n = 0;
      while (gnt_n[i] !== 1'b0) begin
         if (n == lim) begin
            chk("grant wait", 8'h00, 8'h01);
            return;
         end
         n++;
         @(posedge clock);
         #1;
      end
   endtask
   task automatic wait_frame(input logic v);
      int n;
      n = 0;
      while (frame_n !== v) begin
         if (n == 8) begin
            chk("frame wait", 8'h00, 8'h01);
            return;
         end
         n++;
         @(posedge clock);
         #1;
      end
   endtask
   // counts grant cycles, capped at 40 so a stuck grant shows as 40
   task automatic hold_len(input int i, output int n);
      n = 0;
      while (gnt_n[i] === 1'b0 && n < 40) begin
         n++;
         @(posedge clock);
         #1;
      end
   endtask
   task automatic no_gnt(input int i, input int cyc);
      int n;
      n = 0;
      repeat (cyc) begin
         @(posedge clock);
         #1;
         if (gnt_n[i] !== 1'b1) n++;
      end
      chk("refused grant", 8'h00, 8'(n));
   endtask
   task automatic drop_req();
      @(posedge clock);
      want <= 6'h00;
      repeat (3) @(posedge clock);
   endtask
   task automatic t_reset();
      chk("parked bridge", 8'h01, {7'h00, brg_gnt});
      rd_chk(OFS_ARB_CTRL, 8'h40, "arb ctrl");
      rd_chk(OFS_REQ_MASK, 8'h00, "req mask");
      rd_chk(OFS_TMO_FLAG, 8'h00, "flags");
      rd_chk(8'he0, 8'h00, "unmapped");
      $display("reset test done");
   endtask
   task automatic t_no_timeout();
      int n;
      @(posedge clock);
      want <= 6'h04;
      wait_gnt(2, 8);
      hold_len(2, n);
      chk("held grant", 8'h28, 8'(n));
      drop_req();
      rd_chk(OFS_TMO_FLAG, 8'h00, "no flag");
      $display("disabled time-out test done");
   endtask
   // every request times out once; each flag is read and then gone
   task automatic t_timeout();
      int n;
      cfg_wr(OFS_REQ_MASK, 8'h80);
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         want <= 6'h01 << i;
         wait_gnt(i, 8);
         hold_len(i, n);
         chk("grant cycles", 8'(TMO_CLKS), 8'(n));
         drop_req();
         rd_chk(OFS_TMO_FLAG, 8'h01 << i, "flag set");
         rd_chk(OFS_TMO_FLAG, 8'h00, "flag cleared");
      end
      $display("time-out test done");
   endtask
   task automatic t_automask();
      int n;
      cfg_wr(OFS_REQ_MASK, 8'hc0);
      @(posedge clock);
      want <= 6'h08;
      wait_gnt(3, 8);
      hold_len(3, n);
      chk("grant cycles", 8'h10, 8'(n));
      no_gnt(3, 30);
      rd_chk(OFS_TMO_FLAG, 8'h08, "masked flag");
      wait_gnt(3, 8);
      drop_req();
      rd_chk(OFS_TMO_FLAG, 8'h00, "flag after unmask");
      $display("auto mask test done");
   endtask
   task automatic t_ignore();
      cfg_wr(OFS_REQ_MASK, 8'h01);
      @(posedge clock);
      want <= 6'h01;
      no_gnt(0, 20);
      cfg_wr(OFS_REQ_MASK, 8'h00);
      wait_gnt(0, 8);
      drop_req();
      $display("ignore test done");
   endtask
   task automatic t_transfer();
      cfg_wr(OFS_REQ_MASK, 8'h80);
      @(posedge clock);
      want <= 6'h02;
      resp <= 6'h02;
      wait_gnt(1, 8);
      wait_frame(1'b0);
      @(posedge clock);
      want <= 6'h00;
      wait_frame(1'b1);
      repeat (20) @(posedge clock);
      #1;
      chk("parked master", 8'h3d, {2'b00, gnt_n});
      chk("bridge off", 8'h00, {7'h00, brg_gnt});
      rd_chk(OFS_TMO_FLAG, 8'h00, "served flag");
      cfg_wr(OFS_ARB_CTRL, 8'hc0);
      repeat (2) @(posedge clock);
      #1;
      chk("bridge park", 8'h01, {7'h00, brg_gnt});
      chk("masters off", 8'h3f, {2'b00, gnt_n});
      $display("transfer and park test done");
   endtask
   // bridge in the high tier beats low-tier masters; then high-tier request zero wins
   task automatic t_tier();
      cfg_wr(OFS_REQ_MASK, 8'h00);
      cfg_wr(OFS_ARB_CTRL, 8'h41);
      @(posedge clock);
      resp    <= 6'h00;
      want    <= 6'h03;
      brg_req <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk("bridge tier", 8'h01, {7'h00, brg_gnt});
      chk("low tier held", 8'h3f, {2'b00, gnt_n});
      @(posedge clock);
      brg_req <= 1'b0;
      wait_gnt(0, 8);
      chk("tier zero", 8'h3e, {2'b00, gnt_n});
      drop_req();
      $display("tier test done");
   endtask
   task automatic t_fundamental_reset_n();
      cfg_wr(OFS_REQ_MASK, 8'hc1);
      rd_chk(OFS_REQ_MASK, 8'hc1, "mask written");
      @(posedge clock);
      global_reset_n_n <= 1'b0;
      repeat (2) @(posedge clock);
      global_reset_n_n <= 1'b1;
      rd_chk(OFS_REQ_MASK, 8'h00, "mask after reset");
      rd_chk(OFS_ARB_CTRL, 8'h40, "ctrl after reset");
      $display("global reset test done");
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      t_reset();
      t_no_timeout();
      t_timeout();
      t_automask();
      t_ignore();
      t_transfer();
      t_tier();
      t_fundamental_reset_n();
      give_verdict();
   end
endmodule
`default_nettype wire
